// File: hdl/reset_cause_params.svh
/*
 * Offsets, field positions, reset values and encodings for the reset-cause block.
 * Included by the package, by reset_cause_status and by the checker and bench; holds definitions only.
 */
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH

// word indices of the two core registers; one aligned word each
`define IDX_RESET_CAUSE 12'h08E
`define IDX_STATUS 12'h003
// apb byte addresses
`define OFF_RESET_CAUSE (`IDX_RESET_CAUSE << 2)
`define OFF_STATUS (`IDX_STATUS << 2)
`define OFF_IRQ_STATUS 12'h100
`define OFF_IRQ_ENABLE 12'h104
`define OFF_IRQ_CLEAR 12'h108
`define OFF_PC 12'h10C
`define OFF_WAKE_FLAGS 12'h110
`define ADDR_W 12

// status register field positions
`define ST_BANK_IND 7
`define ST_BANK_HI 6
`define ST_BANK_LO 5
`define ST_EXPIRY 4
`define ST_SLEEP 3
`define ST_ARITH_HI 2

// reset-cause field positions
`define RC_POWER_UP 1
`define RC_SUPPLY_DIP 0
`define RC_MASK 8'h03

// program counter
`define PC_W 13
`define PC_RESET_VEC 13'h0000
`define PC_IRQ_VEC 13'h0004
`define PC_ONE 13'h0001

// event bit positions in the interrupt status
`define EV_POWER 0
`define EV_BROWN 1
`define EV_PIN 2
`define EV_WATCHDOG 3
`define EV_WAKE 4
`define EV_W 5

`define ZERO8 8'h00
`define ZERO32 32'h0000_0000

`endif

// File: hdl/reset_cause_pkg.sv
/*
 * Types shared by the reset-cause block.
 * Assumes reset_cause_params.svh is on the include path.
 */
`include "reset_cause_params.svh"

package reset_cause_pkg;

    // what happened this cycle, highest priority first
    typedef enum logic [2:0] {
        EV_NONE = 3'b000,
        EV_POWER_ON = 3'b001,
        EV_BROWN_OUT = 3'b010,
        EV_PIN_RESET = 3'b011,
        EV_WATCHDOG_RESET = 3'b100,
        EV_WATCHDOG_WAKE = 3'b101,
        EV_IRQ_WAKE = 3'b110
    } cause_e;

    // raw event inputs travelling together
    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic external_reset_pin;
        logic watchdog;
        logic irq_wake;
    } events_s;

    // core state outputs
    typedef struct packed {
        logic [`PC_W-1:0] pc;
        logic pc_load;
        logic vector_pending;
    } core_s;

endpackage : reset_cause_pkg

// File: hdl/cause_decode.sv
/*
 * Turns the raw event inputs into one prioritised cause.
 * Assumes the events are single-cycle pulses synchronous to ref_clk.
 */
module cause_decode
    import reset_cause_pkg::*;
(
    // events and state
    input wire events_s ev,
    input wire logic asleep,
    // result
    output cause_e cause
);

    // a supply failure outranks anything the core or watchdog reports
    always_comb begin
        cause = EV_NONE;
        if (ev.power_on) begin
            cause = EV_POWER_ON;
        end else if (ev.brown_out) begin
            cause = EV_BROWN_OUT;
        end else if (ev.external_reset_pin) begin
            cause = EV_PIN_RESET;
        end else if (ev.watchdog) begin
            cause = asleep ? EV_WATCHDOG_WAKE : EV_WATCHDOG_RESET;
        end else if (ev.irq_wake && asleep) begin
            cause = EV_IRQ_WAKE;
        end
    end

endmodule : cause_decode

// File: hdl/irq_events.sv
/*
 * Sticky event status, enable mask and write-one-to-clear, one level output.
 * Assumes clear and set pulses come from the same clock domain.
 */
module irq_events
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // events and software control
    input wire logic [`EV_W-1:0] set_pulse,
    input wire logic [`EV_W-1:0] clear_pulse,
    input wire logic enable_wr,
    input wire logic [`EV_W-1:0] enable_data,
    // state
    output logic [`EV_W-1:0] status_reg,
    output logic [`EV_W-1:0] enable_reg,
    output logic irq
);

    // set beats clear so a coincident event is never lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clear_pulse) | set_pulse;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enable_reg <= '0;
        end else if (enable_wr) begin
            enable_reg <= enable_data;
        end
    end

    assign irq = |(status_reg & enable_reg);

endmodule : irq_events

// File: hdl/reset_cause_status.sv
/*
 * Reset and wake-up cause recorder: reset-cause flags, watchdog-expiry and
 * sleep flags of the processor status, program counter load and interrupt
 * vector redirect after an interrupt wake, all behind an APB slave.
 * Assumes event inputs are one-cycle pulses synchronous to ref_clk, and that
 * the core reports sleep entry and instruction retirement by pulses.
 */
// Register access over APB is this design's own decision.
// Contract
// - Power-on, brown-out, pin and watchdog resets load the program counter with zero.
// - The reset-cause register holds only a power-up bit 1 and supply-dip bit 0, rest zero.
// - Power-up sets status to bank zero, expiry and sleep set, and clears power-up flag.
// - Brown-out clears supply-dip and sets power-up; other resets keep supply-dip.
// - A pin reset while running clears only the bank bits of the status.
// - A pin reset while asleep clears banks, sets expiry and clears sleep.
// - A watchdog reset while running clears banks and expiry and restarts at zero.
// - A wake resumes at the next address, clears sleep, sets expiry on interrupt, clears on watchdog.
// - An interrupt wake with global enable runs the next instruction and then takes the vector.
// - An interrupt wake leaves at least one interrupt flag set naming the source.
`include "reset_cause_params.svh"

module reset_cause_status
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset and wake events
    input wire events_s ev,
    // core side
    input wire logic sleep_enter,
    input wire logic instr_retire,
    input wire logic global_irq_enable,
    input wire logic [7:0] wake_source_flags,
    output core_s core,
    output logic asleep,
    // interrupt
    output logic irq
);

    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [1:0] cause_flags_reg;
    logic [1:0] cause_flags_next;
    logic [`PC_W-1:0] pc_reg;
    logic pc_load_reg;
    logic vector_wait_reg;
    logic [7:0] wake_flags_reg;
    logic asleep_reg;
    cause_e cause;
    logic wr_en;
    logic rd_en;
    logic wr_status;
    logic wr_cause;
    logic wr_wake;
    logic wr_irq_enable;
    logic wr_irq_clear;
    logic [`EV_W-1:0] ev_set;
    logic [`EV_W-1:0] ev_clear;
    logic [`EV_W-1:0] ev_status;
    logic [`EV_W-1:0] ev_enable;
    logic [31:0] rdata_next;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [7:0] bank_clear(input logic [7:0] s);
        bank_clear = s;
        bank_clear[`ST_BANK_IND] = 1'b0;
        bank_clear[`ST_BANK_HI] = 1'b0;
        bank_clear[`ST_BANK_LO] = 1'b0;
    endfunction : bank_clear

    // one register's low byte written in the access cycle
    function automatic logic lane_write(input logic we, input logic [`ADDR_W-1:0] a,
            input logic [`ADDR_W-1:0] off, input logic lane);
        lane_write = we && lane && hit(a, off);
    endfunction : lane_write

    // hardware-owned expiry and sleep flags ignore software writes
    function automatic logic [7:0] status_write(input logic [7:0] s, input logic [7:0] d);
        status_write = d;
        status_write[`ST_EXPIRY] = s[`ST_EXPIRY];
        status_write[`ST_SLEEP] = s[`ST_SLEEP];
    endfunction : status_write

    cause_decode u_decode (
        .ev(ev),
        .asleep(asleep_reg),
        .cause(cause)
    );

    // zero wait state slave: answer in the access cycle; read data is
    // captured in the setup cycle so it already stands when pready is seen
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_status = lane_write(wr_en, paddr, `OFF_STATUS, pstrb[0]);
    assign wr_cause = lane_write(wr_en, paddr, `OFF_RESET_CAUSE, pstrb[0]);
    assign wr_wake = lane_write(wr_en, paddr, `OFF_WAKE_FLAGS, pstrb[0]);
    assign wr_irq_enable = lane_write(wr_en, paddr, `OFF_IRQ_ENABLE, pstrb[0]);
    assign wr_irq_clear = lane_write(wr_en, paddr, `OFF_IRQ_CLEAR, pstrb[0]);

    // status register next value
    always_comb begin
        status_next = status_reg;
        unique case (cause)
            EV_POWER_ON, EV_BROWN_OUT: begin
                // arithmetic flags unknown after power-up; cleared here
                status_next = `ZERO8;
                status_next[`ST_EXPIRY] = 1'b1;
                status_next[`ST_SLEEP] = 1'b1;
            end
            EV_PIN_RESET: begin
                status_next = bank_clear(status_reg);
                if (asleep_reg) begin
                    status_next[`ST_EXPIRY] = 1'b1;
                    status_next[`ST_SLEEP] = 1'b0;
                end
            end
            EV_WATCHDOG_RESET: begin
                status_next = bank_clear(status_reg);
                status_next[`ST_EXPIRY] = 1'b0;
            end
            EV_WATCHDOG_WAKE: begin
                status_next[`ST_EXPIRY] = 1'b0;
                status_next[`ST_SLEEP] = 1'b0;
            end
            EV_IRQ_WAKE: begin
                status_next[`ST_EXPIRY] = 1'b1;
                status_next[`ST_SLEEP] = 1'b0;
            end
            EV_NONE: begin
                if (wr_status) begin
                    status_next = status_write(status_reg, pwdata[7:0]);
                end
            end
            default: begin
                status_next = status_reg;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_reg <= `ZERO8;
        end else begin
            status_reg <= status_next;
        end
    end

    // reset-cause flags; hardware events beat software writes
    always_comb begin
        cause_flags_next = cause_flags_reg;
        if (cause == EV_POWER_ON) begin
            cause_flags_next[`RC_POWER_UP] = 1'b0;
        end else if (cause == EV_BROWN_OUT) begin
            cause_flags_next[`RC_POWER_UP] = 1'b1;
            cause_flags_next[`RC_SUPPLY_DIP] = 1'b0;
        end else if (wr_cause) begin
            cause_flags_next = pwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cause_flags_reg <= 2'b00;
        end else begin
            cause_flags_reg <= cause_flags_next;
        end
    end

    // sleep state follows the core; any reset or wake leaves sleep
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            asleep_reg <= 1'b0;
        end else if (cause != EV_NONE) begin
            asleep_reg <= 1'b0;
        end else if (sleep_enter) begin
            asleep_reg <= 1'b1;
        end
    end

    // program counter load
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pc_reg <= `PC_RESET_VEC;
            pc_load_reg <= 1'b0;
        end else begin
            pc_load_reg <= 1'b0;
            unique case (cause)
                EV_POWER_ON, EV_BROWN_OUT, EV_PIN_RESET, EV_WATCHDOG_RESET: begin
                    pc_reg <= `PC_RESET_VEC;
                    pc_load_reg <= 1'b1;
                end
                EV_WATCHDOG_WAKE, EV_IRQ_WAKE: begin
                    pc_reg <= pc_reg + `PC_ONE;
                    pc_load_reg <= 1'b1;
                end
                EV_NONE: begin
                    if (vector_wait_reg && instr_retire) begin
                        // vector only after the post-sleep instruction retires
                        pc_reg <= `PC_IRQ_VEC;
                        pc_load_reg <= 1'b1;
                    end
                end
                default: begin
                    pc_load_reg <= 1'b0;
                end
            endcase
        end
    end

    // redirect armed by an enabled interrupt wake; any other cause drops it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vector_wait_reg <= 1'b0;
        end else if (cause == EV_IRQ_WAKE) begin
            vector_wait_reg <= global_irq_enable;
        end else if (cause != EV_NONE || instr_retire) begin
            vector_wait_reg <= 1'b0;
        end
    end

    // wake source capture; ensures a flag names an interrupt wake
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wake_flags_reg <= `ZERO8;
        end else if (cause == EV_IRQ_WAKE) begin
            wake_flags_reg <= wake_source_flags | {7'h00, ~|wake_source_flags};
        end else if (wr_wake) begin
            wake_flags_reg <= wake_flags_reg & ~pwdata[7:0];
        end
    end

    // interrupt events
    always_comb begin
        ev_set = '0;
        ev_set[`EV_POWER] = (cause == EV_POWER_ON);
        ev_set[`EV_BROWN] = (cause == EV_BROWN_OUT);
        ev_set[`EV_PIN] = (cause == EV_PIN_RESET);
        ev_set[`EV_WATCHDOG] = (cause == EV_WATCHDOG_RESET) || (cause == EV_WATCHDOG_WAKE);
        ev_set[`EV_WAKE] = (cause == EV_IRQ_WAKE) || (cause == EV_WATCHDOG_WAKE);
    end

    assign ev_clear = wr_irq_clear ? pwdata[`EV_W-1:0] : '0;

    irq_events u_irq (
        .ref_clk(ref_clk),
        .srst(srst),
        .set_pulse(ev_set),
        .clear_pulse(ev_clear),
        .enable_wr(wr_irq_enable),
        .enable_data(pwdata[`EV_W-1:0]),
        .status_reg(ev_status),
        .enable_reg(ev_enable),
        .irq(irq)
    );

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_next = `ZERO32;
        if (hit(paddr, `OFF_RESET_CAUSE)) begin
            rdata_next[7:0] = {6'h00, cause_flags_reg} & `RC_MASK;
        end else if (hit(paddr, `OFF_STATUS)) begin
            rdata_next[7:0] = status_reg;
        end else if (hit(paddr, `OFF_IRQ_STATUS)) begin
            rdata_next[`EV_W-1:0] = ev_status;
        end else if (hit(paddr, `OFF_IRQ_ENABLE)) begin
            rdata_next[`EV_W-1:0] = ev_enable;
        end else if (hit(paddr, `OFF_PC)) begin
            rdata_next[`PC_W-1:0] = pc_reg;
        end else if (hit(paddr, `OFF_WAKE_FLAGS)) begin
            rdata_next[7:0] = wake_flags_reg;
        end
    end

    // registered read data, latched in the setup cycle so it is valid in access
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= `ZERO32;
        end else if (rd_en) begin
            prdata <= rdata_next;
        end
    end

    assign core.pc = pc_reg;
    assign core.pc_load = pc_load_reg;
    assign core.vector_pending = vector_wait_reg;
    assign asleep = asleep_reg;

endmodule : reset_cause_status

// File: dv/reset_cause_checker.sv
/*
 * Concurrent checks on the reset-cause block's ports, bound into reset_cause_status.
 * Assumes the package and reset_cause_params.svh are compiled and included first.
 */
`include "reset_cause_params.svh"

module reset_cause_checker
    import reset_cause_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    // events and core
    input wire events_s ev,
    input wire logic instr_retire,
    input wire logic global_irq_enable,
    input wire core_s core,
    input wire logic asleep
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // reset-class causes that outrank any wake
    wire logic any_rst = ev.power_on | ev.brown_out | ev.external_reset_pin;
    wire logic irq_only = !any_rst && !ev.watchdog && ev.irq_wake;

    AST_PC_ZERO: assert property (
        (any_rst || (ev.watchdog && !asleep)) |=> core.pc == `PC_RESET_VEC && core.pc_load)
        else $error("pc not restarted at zero");
    AST_CAUSE_UPPER: assert property (
        (psel && !penable && !pwrite && paddr == `OFF_RESET_CAUSE) |=> prdata[31:2] == '0)
        else $error("unused cause bits not zero");
    AST_WAKE_PC: assert property (
        (asleep && !any_rst && (ev.watchdog || ev.irq_wake))
        |=> core.pc == $past(core.pc) + `PC_ONE && core.pc_load && !asleep)
        else $error("wake did not resume at next address");
    AST_VEC_PEND: assert property (
        (asleep && irq_only && global_irq_enable) |=> core.vector_pending)
        else $error("vector not pending after enabled wake");
    AST_NO_VEC: assert property (
        (asleep && irq_only && !global_irq_enable) |=> !core.vector_pending)
        else $error("vector pending without global enable");
    AST_VEC_LOAD: assert property (
        (core.vector_pending && instr_retire && ev == 5'h00)
        |=> core.pc == `PC_IRQ_VEC && core.pc_load && !core.vector_pending)
        else $error("vector not taken after next instruction");
    AST_PIN_ASLEEP: assert property (
        (asleep && ev.external_reset_pin) |=> !asleep && core.pc == `PC_RESET_VEC)
        else $error("pin reset left core asleep");
    AST_WDT_AWAKE: assert property (
        (!asleep && ev.watchdog && !any_rst) |=> !asleep && core.pc_load)
        else $error("watchdog reset misbehaved");
    AST_IRQ_IGNORED: assert property (
        (!asleep && irq_only && !instr_retire) |=> $stable(core.pc) && !core.pc_load)
        else $error("wake taken while awake");
endmodule : reset_cause_checker

bind reset_cause_status reset_cause_checker chk_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .ev(ev),
    .instr_retire(instr_retire), .global_irq_enable(global_irq_enable), .core(core),
    .asleep(asleep));

// File: dv/test_reset_cause_status.sv
/*
 * Self-checking bench for reset_cause_status against an integer model.
 * Assumes the package, header and checker are compiled before it.
 */
`include "reset_cause_params.svh"

module test_reset_cause_status
    import reset_cause_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic sleep_enter = 0, instr_retire = 0, global_irq_enable = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [7:0] wsf = '0;
    logic pready, pslverr, asleep, irq;
    events_s ev = '0;
    core_s core;
    int fail_count = 0, samples_checked = 0, st, fl, pc, sticky, en, sl, d;

    reset_cause_status dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ev(ev), .sleep_enter(sleep_enter),
        .instr_retire(instr_retire), .global_irq_enable(global_irq_enable),
        .wake_source_flags(wsf), .core(core), .asleep(asleep), .irq(irq));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // idle cycle at the end keeps back-to-back calls from double-driving psel
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dw;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, r);
        chk("pslverr", 32'h0, pslverr);
    endtask : rd

    task automatic check_all;
        rd(`OFF_STATUS, st, "status");
        rd(`OFF_RESET_CAUSE, fl, "cause");
        rd(`OFF_IRQ_STATUS, sticky, "irq_status");
        rd(`OFF_IRQ_ENABLE, en, "irq_enable");
        rd(`OFF_PC, pc, "pc_read");
        chk("pc", pc, core.pc);
        chk("irq", ((sticky & en) != 0), irq);
        chk("asleep", sl, asleep);
    endtask : check_all

    task automatic pulse_sleep;
        sleep_enter <= 1'b1;
        @(posedge ref_clk);
        sleep_enter <= 1'b0;
        sl = 1;
        @(posedge ref_clk);
    endtask : pulse_sleep

    // k: 0 power-on, 1 brown-out, 2 pin, 3 watchdog, 4 interrupt wake
    task automatic fire(input int k);
        ev <= events_s'(5'h10 >> k);
        @(posedge ref_clk);
        ev <= '0;
        @(posedge ref_clk);
        case (k)
            0: begin st = 8'h18; fl = fl & 1; end
            1: begin st = 8'h18; fl = 2; end
            2: st = sl ? (st & 7) | 8'h10 : st & 8'h1F;
            3: st = sl ? st & 8'hE7 : st & 8'h0F;
            default: if (sl) st = (st & 8'hE7) | 8'h10;
        endcase
        if (k < 3 || !sl) pc = (k == 4) ? pc : 0;
        else pc = pc + 1;
        if (k < 4) sticky |= 1 << k;
        if (sl && k >= 3) sticky |= 16;
        sl = 0;
    endtask : fire

    task automatic do_reset;
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        {st, fl, pc, sticky, en, sl} = '0;
        @(posedge ref_clk);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        print_verdict;
    end

    initial begin
        d = $urandom(32'h5BA12F46);
        do_reset;
        check_all;
        apb(1'b1, `OFF_RESET_CAUSE, 32'hFFFF_FFFF);
        fl = 3;
        check_all;
        for (int i = 0; i < 10; i++) begin
            d = $urandom_range(255);
            apb(1'b1, `OFF_STATUS, d);
            st = (st & 8'h18) | (d & 8'hE7);
            wsf <= 8'($urandom_range(255, 1));
            if (i >= 5) pulse_sleep;
            fire(i % 5);
            check_all;
        end
        apb(1'b0, `OFF_WAKE_FLAGS, 32'h0);
        chk("wake_flags", wsf, r[7:0] & wsf);
        apb(1'b1, `OFF_WAKE_FLAGS, 32'hFF);
        rd(`OFF_WAKE_FLAGS, 32'h0, "wake_flags_clear");
        global_irq_enable <= 1'b1;
        pulse_sleep;
        fire(4);
        check_all;
        instr_retire <= 1'b1;
        @(posedge ref_clk);
        instr_retire <= 1'b0;
        @(posedge ref_clk);
        pc = 4;
        chk("vector_pc", pc, core.pc);
        global_irq_enable <= 1'b0;
        apb(1'b1, `OFF_IRQ_ENABLE, 32'h1F);
        en = 31;
        apb(1'b1, `OFF_IRQ_STATUS, 32'h0);
        check_all;
        apb(1'b1, `OFF_IRQ_CLEAR, 32'h1F);
        sticky = 0;
        check_all;
        fire(2);
        check_all;
        apb(1'b1, `OFF_IRQ_ENABLE, 32'h1B);
        en = 27;
        check_all;
        rd(12'h200, 32'h0, "unmapped");
        do_reset;
        check_all;
        print_verdict;
    end
endmodule : test_reset_cause_status
